//--- shared/ccd_pkg.sv
/*
 * Constants, register map and types of the compensation combiner and distributor.
 * Assumes a 20 MHz clock and a byte-wide register port with word-spaced registers.
 */
`default_nettype none

package ccd_pkg;

   // ****************************************************************
   // Widths and fixed-point format.
   // ****************************************************************
   localparam int FACTOR_W = 32;
   localparam int FRAC_W = 40;
   localparam int PROD_W = 64;
   localparam int SUM_W = 34;
   localparam int SEL_W = 3;
   localparam int NUM_DEST = 6;
   localparam int NUM_COMP = 8;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;

   typedef logic signed [FACTOR_W-1:0] ccd_factor_t;
   typedef logic [SEL_W-1:0] ccd_sel_t;

   localparam logic signed [FACTOR_W-1:0] FACTOR_MAX = 32'sh7fffffff;
   localparam logic signed [FACTOR_W-1:0] FACTOR_MIN = -32'sh7fffffff - 32'sh00000001;
   localparam logic signed [FACTOR_W-1:0] FACTOR_ZERO = 32'sh00000000;

   // ****************************************************************
   // Composite index bits and destinations.
   // ****************************************************************
   localparam int COMP_BIT_ONE = 0;
   localparam int COMP_BIT_TWO = 1;
   localparam int COMP_BIT_THREE = 2;
   localparam ccd_sel_t SEL_NONE = 3'h0;
   localparam ccd_sel_t SLEW_UNLIMITED = 3'h0;

   localparam int DEST_AUX_DPLL = 0;
   localparam int DEST_TDC = 1;
   localparam int DEST_AUX_NCO0 = 2;
   localparam int DEST_AUX_NCO1 = 3;
   localparam int DEST_LOOP0 = 4;
   localparam int DEST_LOOP1 = 5;

   // ****************************************************************
   // Register map: offsets are register indices, byte address is four times.
   // ****************************************************************
   localparam int REG_IDX_SEL_AUX = 'h280;
   localparam int REG_IDX_SEL_NCO = 'h281;
   localparam int REG_IDX_SEL_LOOP = 'h282;
   localparam int REG_IDX_SLEW = 'h283;
   localparam int REG_IDX_STATUS = 'h290;
   localparam logic [ADDR_W-1:0] ADDR_SEL_AUX = 12'(REG_IDX_SEL_AUX * 4);
   localparam logic [ADDR_W-1:0] ADDR_SEL_NCO = 12'(REG_IDX_SEL_NCO * 4);
   localparam logic [ADDR_W-1:0] ADDR_SEL_LOOP = 12'(REG_IDX_SEL_LOOP * 4);
   localparam logic [ADDR_W-1:0] ADDR_SLEW = 12'(REG_IDX_SLEW * 4);
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'(REG_IDX_STATUS * 4);

   localparam int FLD_LO_LSB = 0;
   localparam int FLD_HI_LSB = 3;
   localparam ccd_sel_t SEL_RESET = 3'h0;
   localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;

   // ****************************************************************
   // Timing of the slew limiter.
   // ****************************************************************
   localparam int CLK_PERIOD_NS = 50;
   localparam int TICK_PERIOD_US = 1000;
   localparam int TICK_CYCLES_DEF = TICK_PERIOD_US * 1000 / CLK_PERIOD_NS;
   localparam int TICK_CNT_W = 24;
   localparam longint SLEW_BASE_PPB_PER_S = 715;
   localparam longint LSB_PER_E9 = 1099;
   localparam longint NS_PER_S = 1000000000;

endpackage

`default_nettype wire

//--- design/ccd_slew_limiter.sv
/*
 * One channel of the slew-rate limiter for a composite factor.
 * Assumes a one-cycle tick pulse and a base step already scaled to the tick period.
 */
`default_nettype none

module ccd_slew_limiter (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic tick,
   input wire logic [ccd_pkg::SEL_W-1:0] code,
   input wire logic [ccd_pkg::FACTOR_W-1:0] base_step,
   input wire logic signed [ccd_pkg::FACTOR_W-1:0] target,
   output logic signed [ccd_pkg::FACTOR_W-1:0] value,
   output logic limiting
);

   // ****************************************************************
   // Step bound and next value.
   // ****************************************************************
   logic signed [ccd_pkg::FACTOR_W-1:0] value_ff;
   logic signed [ccd_pkg::FACTOR_W-1:0] nxt_value;
   logic limiting_ff;
   logic nxt_limiting;
   logic signed [ccd_pkg::SUM_W-1:0] diff;
   logic signed [ccd_pkg::SUM_W-1:0] step;
   logic [ccd_pkg::SEL_W-1:0] shift;

   always_comb begin
      shift = code - 3'h1;
      step = ccd_pkg::SUM_W'(base_step << shift);
      diff = ccd_pkg::SUM_W'(target) - ccd_pkg::SUM_W'(value_ff);
      nxt_value = value_ff;
      nxt_limiting = limiting_ff;
      if (code == ccd_pkg::SLEW_UNLIMITED) begin
         nxt_value = target;
         nxt_limiting = 1'b0;
      end else if (tick) begin
         if (diff > step) begin
            nxt_value = ccd_pkg::FACTOR_W'(ccd_pkg::SUM_W'(value_ff) + step);
            nxt_limiting = 1'b1;
         end else if (diff < -step) begin
            nxt_value = ccd_pkg::FACTOR_W'(ccd_pkg::SUM_W'(value_ff) - step);
            nxt_limiting = 1'b1;
         end else begin
            nxt_value = target;
            nxt_limiting = 1'b0;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         value_ff <= ccd_pkg::FACTOR_ZERO;
         limiting_ff <= 1'b0;
      end else begin
         value_ff <= nxt_value;
         limiting_ff <= nxt_limiting;
      end
   end

   assign value = value_ff;
   assign limiting = limiting_ff;

endmodule

`default_nettype wire

//--- design/ccd_combiner.sv
/*
 * Compensation combiner and distributor: composite factors, slew limiting, routing
 * of composites to six destinations, and the register port that configures them.
 * Assumes method factors arrive on the mclk domain as signed deviations from one,
 * least significant bit two to the minus forty, and a single-cycle register port.
 */
`default_nettype none


module ccd_combiner #(
   parameter int TICK_CYCLES = ccd_pkg::TICK_CYCLES_DEF
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic [ccd_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [ccd_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [ccd_pkg::DATA_W-1:0] reg_rdata,
   input wire logic signed [ccd_pkg::FACTOR_W-1:0] method_one_factor,
   input wire logic signed [ccd_pkg::FACTOR_W-1:0] method_two_factor,
   input wire logic signed [ccd_pkg::FACTOR_W-1:0] method_three_factor,
   output logic signed [ccd_pkg::FACTOR_W-1:0] comp_aux_dpll,
   output logic signed [ccd_pkg::FACTOR_W-1:0] comp_tdc_group,
   output logic signed [ccd_pkg::FACTOR_W-1:0] comp_aux_nco0,
   output logic signed [ccd_pkg::FACTOR_W-1:0] comp_aux_nco1,
   output logic signed [ccd_pkg::FACTOR_W-1:0] comp_first_loop_channel,
   output logic signed [ccd_pkg::FACTOR_W-1:0] comp_second_loop_channel
);

   // ****************************************************************
   // Derived timing.
   // ****************************************************************
   localparam longint STEP_RAW = longint'(TICK_CYCLES) * ccd_pkg::CLK_PERIOD_NS
      * ccd_pkg::SLEW_BASE_PPB_PER_S * ccd_pkg::LSB_PER_E9 / ccd_pkg::NS_PER_S;
   localparam logic [ccd_pkg::FACTOR_W-1:0] BASE_STEP =
      (STEP_RAW < 1) ? 32'h00000001 : ccd_pkg::FACTOR_W'(STEP_RAW);
   localparam logic [ccd_pkg::TICK_CNT_W-1:0] TICK_LAST =
      ccd_pkg::TICK_CNT_W'(TICK_CYCLES - 1);

   // ****************************************************************
   // Fixed-point combination of two factors.
   // ****************************************************************
   // Factors are deviations from one, so (1+a)(1+b)-1 = a+b+ab, saturated.
   function automatic ccd_pkg::ccd_factor_t ccd_combine(
      input ccd_pkg::ccd_factor_t a,
      input ccd_pkg::ccd_factor_t b
   );
      logic signed [ccd_pkg::PROD_W-1:0] prod;
      logic signed [ccd_pkg::SUM_W-1:0] sum;
      begin
         prod = ccd_pkg::PROD_W'(a) * ccd_pkg::PROD_W'(b);
         sum = ccd_pkg::SUM_W'(a) + ccd_pkg::SUM_W'(b)
            + ccd_pkg::SUM_W'(prod >>> ccd_pkg::FRAC_W);
         if (sum > ccd_pkg::SUM_W'(ccd_pkg::FACTOR_MAX)) begin
            ccd_combine = ccd_pkg::FACTOR_MAX;
         end else if (sum < ccd_pkg::SUM_W'(ccd_pkg::FACTOR_MIN)) begin
            ccd_combine = ccd_pkg::FACTOR_MIN;
         end else begin
            ccd_combine = ccd_pkg::FACTOR_W'(sum);
         end
      end
   endfunction

   // Selects one composite by index; index zero means no compensation.
   function automatic ccd_pkg::ccd_factor_t ccd_pick(
      input ccd_pkg::ccd_sel_t idx,
      input logic signed [ccd_pkg::NUM_COMP*ccd_pkg::FACTOR_W-1:0] all
   );
      begin
         if (idx == ccd_pkg::SEL_NONE) begin
            ccd_pick = ccd_pkg::FACTOR_ZERO;
         end else begin
            ccd_pick = all[idx*ccd_pkg::FACTOR_W +: ccd_pkg::FACTOR_W];
         end
      end
   endfunction

   // ****************************************************************
   // Register file.
   // ****************************************************************
   logic [ccd_pkg::SEL_W-1:0] sel_ff [ccd_pkg::NUM_DEST];
   logic [ccd_pkg::SEL_W-1:0] nxt_sel [ccd_pkg::NUM_DEST];
   logic [ccd_pkg::SEL_W-1:0] slew_ff;
   logic [ccd_pkg::SEL_W-1:0] nxt_slew;
   logic [ccd_pkg::DATA_W-1:0] rdata_ff;
   logic [ccd_pkg::DATA_W-1:0] nxt_rdata;
   logic [ccd_pkg::NUM_COMP-1:0] limiting;

   always_comb begin
      for (int d = 0; d < ccd_pkg::NUM_DEST; d++) begin
         nxt_sel[d] = sel_ff[d];
      end
      nxt_slew = slew_ff;
      nxt_rdata = ccd_pkg::DATA_ZERO;
      if (reg_wr) begin
         case (reg_addr)
            ccd_pkg::ADDR_SEL_AUX: begin
               nxt_sel[ccd_pkg::DEST_AUX_DPLL] = reg_wdata[ccd_pkg::FLD_LO_LSB +: ccd_pkg::SEL_W];
               nxt_sel[ccd_pkg::DEST_TDC] = reg_wdata[ccd_pkg::FLD_HI_LSB +: ccd_pkg::SEL_W];
            end
            ccd_pkg::ADDR_SEL_NCO: begin
               nxt_sel[ccd_pkg::DEST_AUX_NCO0] = reg_wdata[ccd_pkg::FLD_LO_LSB +: ccd_pkg::SEL_W];
               nxt_sel[ccd_pkg::DEST_AUX_NCO1] = reg_wdata[ccd_pkg::FLD_HI_LSB +: ccd_pkg::SEL_W];
            end
            ccd_pkg::ADDR_SEL_LOOP: begin
               nxt_sel[ccd_pkg::DEST_LOOP0] = reg_wdata[ccd_pkg::FLD_LO_LSB +: ccd_pkg::SEL_W];
               nxt_sel[ccd_pkg::DEST_LOOP1] = reg_wdata[ccd_pkg::FLD_HI_LSB +: ccd_pkg::SEL_W];
            end
            ccd_pkg::ADDR_SLEW: begin
               nxt_slew = reg_wdata[ccd_pkg::FLD_LO_LSB +: ccd_pkg::SEL_W];
            end
            default: begin
               nxt_slew = slew_ff;
            end
         endcase
      end
      if (reg_rd) begin
         case (reg_addr)
            ccd_pkg::ADDR_SEL_AUX: begin
               nxt_rdata = {2'h0, sel_ff[ccd_pkg::DEST_TDC], sel_ff[ccd_pkg::DEST_AUX_DPLL]};
            end
            ccd_pkg::ADDR_SEL_NCO: begin
               nxt_rdata = {2'h0, sel_ff[ccd_pkg::DEST_AUX_NCO1], sel_ff[ccd_pkg::DEST_AUX_NCO0]};
            end
            ccd_pkg::ADDR_SEL_LOOP: begin
               nxt_rdata = {2'h0, sel_ff[ccd_pkg::DEST_LOOP1], sel_ff[ccd_pkg::DEST_LOOP0]};
            end
            ccd_pkg::ADDR_SLEW: begin
               nxt_rdata = {5'h00, slew_ff};
            end
            ccd_pkg::ADDR_STATUS: begin
               nxt_rdata = limiting;
            end
            default: begin
               nxt_rdata = ccd_pkg::DATA_ZERO;
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         for (int d = 0; d < ccd_pkg::NUM_DEST; d++) begin
            sel_ff[d] <= ccd_pkg::SEL_RESET;
         end
         slew_ff <= ccd_pkg::SLEW_UNLIMITED;
         rdata_ff <= ccd_pkg::DATA_ZERO;
      end else begin
         for (int d = 0; d < ccd_pkg::NUM_DEST; d++) begin
            sel_ff[d] <= nxt_sel[d];
         end
         slew_ff <= nxt_slew;
         rdata_ff <= nxt_rdata;
      end
   end

   assign reg_rdata = rdata_ff;

   // ****************************************************************
   // Limiter update tick.
   // ****************************************************************
   logic [ccd_pkg::TICK_CNT_W-1:0] tick_cnt_ff;
   logic [ccd_pkg::TICK_CNT_W-1:0] nxt_tick_cnt;
   logic tick_ff;
   logic nxt_tick;

   always_comb begin
      nxt_tick = 1'b0;
      nxt_tick_cnt = tick_cnt_ff + 24'h000001;
      if (tick_cnt_ff >= TICK_LAST) begin
         nxt_tick_cnt = '0;
         nxt_tick = 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         tick_cnt_ff <= '0;
         tick_ff <= 1'b0;
      end else begin
         tick_cnt_ff <= nxt_tick_cnt;
         tick_ff <= nxt_tick;
      end
   end

   // ****************************************************************
   // Combiner and slew limiting.
   // ****************************************************************
   ccd_pkg::ccd_factor_t raw [ccd_pkg::NUM_COMP];
   logic signed [ccd_pkg::NUM_COMP*ccd_pkg::FACTOR_W-1:0] limited;

   always_comb begin
      raw[0] = ccd_pkg::FACTOR_ZERO;
      raw[1] = method_one_factor;
      raw[2] = method_two_factor;
      raw[3] = ccd_combine(method_one_factor, method_two_factor);
      raw[4] = method_three_factor;
      raw[5] = ccd_combine(method_one_factor, method_three_factor);
      raw[6] = ccd_combine(method_two_factor, method_three_factor);
      raw[7] = ccd_combine(raw[3], method_three_factor);
   end

   assign limited[0 +: ccd_pkg::FACTOR_W] = ccd_pkg::FACTOR_ZERO;
   assign limiting[0] = 1'b0;

   genvar c;
   generate
      for (c = 1; c < ccd_pkg::NUM_COMP; c++) begin : g_slew
         // One shared code drives every limiter channel.
         ccd_slew_limiter u_slew (
            .mclk(mclk),
            .resetn(resetn),
            .tick(tick_ff),
            .code(slew_ff),
            .base_step(BASE_STEP),
            .target(raw[c]),
            .value(limited[c*ccd_pkg::FACTOR_W +: ccd_pkg::FACTOR_W]),
            .limiting(limiting[c])
         );
      end
   endgenerate

   // ****************************************************************
   // Distributor.
   // ****************************************************************
   ccd_pkg::ccd_factor_t dest_ff [ccd_pkg::NUM_DEST];
   ccd_pkg::ccd_factor_t nxt_dest [ccd_pkg::NUM_DEST];

   always_comb begin
      for (int d = 0; d < ccd_pkg::NUM_DEST; d++) begin
         nxt_dest[d] = ccd_pick(sel_ff[d], limited);
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         for (int d = 0; d < ccd_pkg::NUM_DEST; d++) begin
            dest_ff[d] <= ccd_pkg::FACTOR_ZERO;
         end
      end else begin
         for (int d = 0; d < ccd_pkg::NUM_DEST; d++) begin
            dest_ff[d] <= nxt_dest[d];
         end
      end
   end

   assign comp_aux_dpll = dest_ff[ccd_pkg::DEST_AUX_DPLL];
   assign comp_tdc_group = dest_ff[ccd_pkg::DEST_TDC];
   assign comp_aux_nco0 = dest_ff[ccd_pkg::DEST_AUX_NCO0];
   assign comp_aux_nco1 = dest_ff[ccd_pkg::DEST_AUX_NCO1];
   assign comp_first_loop_channel = dest_ff[ccd_pkg::DEST_LOOP0];
   assign comp_second_loop_channel = dest_ff[ccd_pkg::DEST_LOOP1];

endmodule

`default_nettype wire

//--- testbench/ccd_dest_model.sv
/*
 * Consumer model of the time-stamp TDC group and its auxiliary NCO time reference.
 * Assumes both composite inputs come from ccd_combiner on the mclk domain.
 */
`default_nettype none

module ccd_dest_model (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic signed [ccd_pkg::FACTOR_W-1:0] comp_tdc_group,
   input wire logic signed [ccd_pkg::FACTOR_W-1:0] comp_aux_nco0,
   output var logic ts_pair_ok_ff
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************************************
   // Flags whether the stamp source and its time reference see one composite.
   // ****************************************************************
   logic nxt_ts_pair_ok;
   always_comb begin
      nxt_ts_pair_ok = (comp_tdc_group === comp_aux_nco0);
      if (!resetn) begin
         nxt_ts_pair_ok = 1'b0;
      end
   end
   always_ff @(posedge mclk) begin
      ts_pair_ok_ff <= nxt_ts_pair_ok;
   end
endmodule

`default_nettype wire

//--- testbench/ccd_combiner_chk.sv
/*
 * Assertions on the register port and composite routing of ccd_combiner.
 * Assumes it is bound to ccd_combiner and sees only its ports.
 */
`default_nettype none

module ccd_combiner_chk #(
   parameter int TICK_CYCLES = ccd_pkg::TICK_CYCLES_DEF
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic [ccd_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [ccd_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [ccd_pkg::DATA_W-1:0] reg_rdata,
   input wire logic signed [ccd_pkg::FACTOR_W-1:0] method_one_factor,
   input wire logic signed [ccd_pkg::FACTOR_W-1:0] comp_aux_nco0,
   input wire logic signed [ccd_pkg::FACTOR_W-1:0] comp_aux_nco1,
   input wire logic signed [ccd_pkg::FACTOR_W-1:0] comp_first_loop_channel
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************************************
   // Shadow registers and properties.
   // ****************************************************************
   localparam longint STEP_RAW = longint'(TICK_CYCLES) * ccd_pkg::CLK_PERIOD_NS *
      ccd_pkg::SLEW_BASE_PPB_PER_S * ccd_pkg::LSB_PER_E9 / ccd_pkg::NS_PER_S;
   localparam longint BSTEP = (STEP_RAW < 1) ? 1 : STEP_RAW;
   logic [7:0] nco_ff, nxt_nco, loop_ff, nxt_loop;
   logic [2:0] slew_ff, nxt_slew;
   logic mapped;
   longint lim;
   assign mapped = reg_addr == ccd_pkg::ADDR_SEL_AUX || reg_addr == ccd_pkg::ADDR_SEL_NCO ||
      reg_addr == ccd_pkg::ADDR_SEL_LOOP || reg_addr == ccd_pkg::ADDR_SLEW ||
      reg_addr == ccd_pkg::ADDR_STATUS;
   assign lim = BSTEP << (slew_ff - 3'h1);
   always_comb begin
      nxt_nco = nco_ff;
      nxt_loop = loop_ff;
      nxt_slew = slew_ff;
      if (!resetn) begin
         nxt_nco = 8'h00;
         nxt_loop = 8'h00;
         nxt_slew = 3'h0;
      end else if (reg_wr && reg_addr == ccd_pkg::ADDR_SEL_NCO) begin
         nxt_nco = reg_wdata & 8'h3f;
      end else if (reg_wr && reg_addr == ccd_pkg::ADDR_SEL_LOOP) begin
         nxt_loop = reg_wdata & 8'h3f;
      end else if (reg_wr && reg_addr == ccd_pkg::ADDR_SLEW) begin
         nxt_slew = reg_wdata[2:0];
      end
   end
   always_ff @(posedge mclk) begin
      nco_ff <= nxt_nco;
      loop_ff <= nxt_loop;
      slew_ff <= nxt_slew;
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);
   rd_idle_zero_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not zero outside a read answer");
   rd_unmapped_a: assert property ($past(reg_rd) && !$past(mapped) |-> reg_rdata == 8'h00)
      else $error("unmapped read returned nonzero data");
   rd_slew_val_a: assert property ($past(reg_rd) && $past(reg_addr) == ccd_pkg::ADDR_SLEW
      |-> reg_rdata == {5'h00, $past(slew_ff)}) else $error("slew code read back wrong");
   wr_rd_echo_a: assert property (reg_wr && reg_addr == ccd_pkg::ADDR_SEL_NCO ##1
      reg_rd && reg_addr == ccd_pkg::ADDR_SEL_NCO |=> reg_rdata == ($past(reg_wdata, 2) & 8'h3f))
      else $error("selection write not seen by following read");
   null_comp_a: assert property ((nco_ff[2:0] == 3'h0) [*3] |-> comp_aux_nco0 == 32'sh0)
      else $error("index zero output not zero");
   pass_thru_a: assert property ((slew_ff == 3'h0 && nco_ff[2:0] == 3'h1) [*3]
      |-> comp_aux_nco0 == $past(method_one_factor, 2)) else $error("unlimited path lags");
   slew_step_a: assert property ((slew_ff != 3'h0 && slew_ff == $past(slew_ff) &&
      nco_ff[2:0] == 3'h1) [*3] |-> longint'(comp_aux_nco0) - longint'($past(comp_aux_nco0)) <= lim
      && longint'($past(comp_aux_nco0)) - longint'(comp_aux_nco0) <= lim)
      else $error("composite step above slew limit");
   same_comp_a: assert property ((nco_ff[2:0] == nco_ff[5:3]) [*3]
      |-> comp_aux_nco0 == comp_aux_nco1) else $error("shared composite differs");
   route_loop_a: assert property ((loop_ff[2:0] == nco_ff[2:0]) [*3]
      |-> comp_first_loop_channel == comp_aux_nco0) else $error("loop zero routing wrong");
   cover property (reg_wr && reg_addr == ccd_pkg::ADDR_SLEW && reg_wdata[2:0] != 3'h0);
   cover property ($past(reg_rd) && $past(reg_addr) == ccd_pkg::ADDR_STATUS && reg_rdata != 0);
   cover property (nco_ff[2:0] == 3'h7 ##1 nco_ff[2:0] == 3'h7);
endmodule

bind ccd_combiner ccd_combiner_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.mclk(mclk),
   .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .method_one_factor(method_one_factor),
   .comp_aux_nco0(comp_aux_nco0), .comp_aux_nco1(comp_aux_nco1),
   .comp_first_loop_channel(comp_first_loop_channel));

`default_nettype wire

//--- testbench/ccd_combiner_test.sv
/*
 * Self-checking bench of ccd_combiner: registers, composite table, routing, slew limit.
 * Assumes the checker is bound in and the destination model sits on two outputs.
 */
`default_nettype none

`define CHK(got, exp) \
   begin \
      compares++; \
      if ((got) !== (exp)) begin \
         n_mismatch++; \
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); \
      end \
   end

module ccd_combiner_test;
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************************************
   // Stimulus, tasks and scenarios.
   // ****************************************************************
   localparam int TICKC = 20;
   localparam longint STEP_RAW = longint'(TICKC) * ccd_pkg::CLK_PERIOD_NS *
      ccd_pkg::SLEW_BASE_PPB_PER_S * ccd_pkg::LSB_PER_E9 / ccd_pkg::NS_PER_S;
   localparam longint BSTEP = (STEP_RAW < 1) ? 1 : STEP_RAW;
   localparam logic [11:0] A_AUX = ccd_pkg::ADDR_SEL_AUX;
   localparam logic [11:0] A_NCO = ccd_pkg::ADDR_SEL_NCO;
   localparam logic [11:0] A_LOOP = ccd_pkg::ADDR_SEL_LOOP;
   localparam logic [11:0] A_SLEW = ccd_pkg::ADDR_SLEW;
   localparam logic [11:0] A_STAT = ccd_pkg::ADDR_STATUS;
   logic mclk, resetn, reg_wr, reg_rd, ts_ok;
   logic [11:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata;
   logic [2:0] s;
   ccd_pkg::ccd_factor_t f1, f2, f3, o_aux, o_tdc, o_n0, o_n1, o_l0, o_l1, v0, v1, step;
   int n_mismatch, compares;
   logic [11:0] amap[6] = '{A_AUX, A_NCO, A_LOOP, A_SLEW, A_STAT, 12'h010};

   ccd_combiner #(.TICK_CYCLES(TICKC)) u_dut (.mclk(mclk), .resetn(resetn),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .method_one_factor(f1), .method_two_factor(f2),
      .method_three_factor(f3), .comp_aux_dpll(o_aux), .comp_tdc_group(o_tdc),
      .comp_aux_nco0(o_n0), .comp_aux_nco1(o_n1), .comp_first_loop_channel(o_l0),
      .comp_second_loop_channel(o_l1));
   ccd_dest_model u_model (.mclk(mclk), .resetn(resetn), .comp_tdc_group(o_tdc),
      .comp_aux_nco0(o_n0), .ts_pair_ok_ff(ts_ok));

   function automatic ccd_pkg::ccd_factor_t comb(ccd_pkg::ccd_factor_t a, ccd_pkg::ccd_factor_t b);
      longint r;
      r = longint'(a) + longint'(b) + ((longint'(a) * longint'(b)) >>> 40);
      if (r > longint'(ccd_pkg::FACTOR_MAX)) r = longint'(ccd_pkg::FACTOR_MAX);
      if (r < longint'(ccd_pkg::FACTOR_MIN)) r = longint'(ccd_pkg::FACTOR_MIN);
      return ccd_pkg::ccd_factor_t'(r);
   endfunction
   function automatic ccd_pkg::ccd_factor_t expc(logic [2:0] i);
      ccd_pkg::ccd_factor_t e;
      e = ccd_pkg::FACTOR_ZERO;
      if (i[0]) e = f1;
      if (i[1]) e = i[0] ? comb(e, f2) : f2;
      if (i[2]) e = (i[1:0] != 2'b00) ? comb(e, f3) : f3;
      return e;
   endfunction
   task automatic cyc(int n);
      repeat (n) begin
         @(posedge mclk);
         reg_wr <= 1'b0;
      end
   endtask
   task automatic wr(logic [11:0] a, logic [7:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
   endtask
   task automatic rd_chk(logic [11:0] a, logic [7:0] mask, logic [7:0] exp);
      @(posedge mclk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      `CHK(reg_rdata & mask, exp)
   endtask
   task automatic set_f(ccd_pkg::ccd_factor_t a, ccd_pkg::ccd_factor_t b,
      ccd_pkg::ccd_factor_t c);
      @(posedge mclk);
      reg_wr <= 1'b0;
      f1 <= a;
      f2 <= b;
      f3 <= c;
   endtask
   task automatic tally_and_finish;
      $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   initial begin
      repeat (20000) @(posedge mclk);
      n_mismatch++;
      tally_and_finish();
   end
   initial begin
      {resetn, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      {f1, f2, f3} = '0;
      repeat (6) @(posedge mclk);
      resetn <= 1'b1;
      for (int i = 0; i < 6; i++) rd_chk(amap[i], 8'hff, 8'h00);
      wr(A_NCO, 8'hff);
      rd_chk(A_NCO, 8'hff, 8'h3f);
      wr(A_SLEW, 8'hff);
      rd_chk(A_SLEW, 8'hff, 8'h07);
      wr(A_SLEW, 8'h00);
      wr(A_STAT, 8'hff);
      rd_chk(A_STAT, 8'hff, 8'h00);
      wr(12'h010, 8'h55);
      rd_chk(12'h010, 8'hff, 8'h00);
      set_f(32'sh10000000, -32'sh08000000, 32'sh04000000);
      for (int i = 0; i < 8; i++) begin
         s = i[2:0];
         wr(A_AUX, {2'b00, s, s & 3'h3});
         wr(A_NCO, {2'b00, ~s, s});
         wr(A_LOOP, {2'b00, s, s & 3'h5});
         cyc(3);
         #1;
         `CHK(o_aux, expc(s & 3'h3))
         `CHK(o_tdc, expc(s))
         `CHK(o_n0, expc(s))
         `CHK(o_n1, expc(~s))
         `CHK(o_l0, expc(s & 3'h5))
         `CHK(o_l1, expc(s))
         `CHK(ts_ok, 1'b1)
      end
      set_f(ccd_pkg::FACTOR_MAX, ccd_pkg::FACTOR_MAX, -32'sh00000001);
      cyc(3);
      #1;
      `CHK(o_n0, expc(3'h7))
      wr(A_NCO, {2'b00, 3'h4, 3'h1});
      for (int c = 1; c < 8; c++) begin
         step = ccd_pkg::ccd_factor_t'(BSTEP << (c - 1));
         wr(A_SLEW, 8'h00);
         set_f(32'sh0, 32'sh0, 32'sh0);
         cyc(4);
         wr(A_SLEW, 8'(c));
         set_f(32'sh00010000, 32'sh0, 32'sh00010000);
         cyc(TICKC + 5);
         #1;
         v0 = o_n0;
         v1 = o_n1;
         cyc(TICKC);
         #1;
         `CHK(o_n0, v0 + step)
         `CHK(o_n1, v1 + step)
         rd_chk(A_STAT, 8'h12, 8'h12);
      end
      cyc(1);
      tally_and_finish();
   end
endmodule

`default_nettype wire
